// [rtl/slope_delta_codec_pll_control_register_bank.sv]
// What this block does
// - Transmit and receive PLLs hold 7-bit swallow and 13-bit main counters.
// - Register 3 low fourteen bits hold the second oscillator divider, default 4.
// - Register 4 low twelve bits hold reference divider, default hex 800.
// - Register 7 bit 13 picks rail swing or current mode for modulus outputs.
// - Charge-pump current selects: 1/20, 2/20, 3/14; one means 400 microamps.
// - Register 7 bits 21 to 23 invert second oscillator, receive, transmit pumps.
// - Register 7 bits 20 to 18 select tank capacitor, default 000.
// - Decoder and encoder minimum step sizes sit in bits 22:21 of registers 1, 2.
// - Register 3 bits 16:15 set codec clock rate, default 11.
// - Register 4 holds codec encoder and filter clock dividers, default 100000.
// - Register 6 bits 3, 4 route receive and transmit pattern generators.
// - Register 7 bit 14 disables codec charge compensation, default zero.
// - Idle detector delay in 5[14:11] default 0111, threshold 5[17:15] default 100.
// - Register 7 bit 2 stops encoder idle action; status bit 5/21 still reports.
// - Slicer invert, modem mode, clock recovery bypass, data detect bypass bits.
// - Register 5 bit 22 reads back the status pin, code word found.
// - Register 7 bits 11, 12 pick 24-bit or 16-bit code and data words.
// - Registers 8, 9 hold transmit words; register 10 returns last received word.
// - Register 7 bit 1 bypasses scrambling; bits 10:8 pick tap, default 010.
// - Register 7 bits 5:4 and 7:6 choose the two multipurpose pin functions.
// - Register 6 bits 0 to 2 mute amplifiers, receive and transmit speech.
// - Register 6 holds receive gain 10:6 default 01111, transmit 15:11 default 00100.
// - Detector threshold, reference trim, carrier mode and output readback bits.
`include "slope_delta_codec_pll_ctrl_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module slope_delta_codec_pll_control_register_bank (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Register port from the serial control interface
  input wire logic WR_STROBE,
  input wire slope_delta_codec_pll_ctrl_pkg::reg_addr_type WR_ADDR,
  input wire slope_delta_codec_pll_ctrl_pkg::word_type WR_DATA,
  input wire slope_delta_codec_pll_ctrl_pkg::reg_addr_type RD_ADDR,
  output logic [23:0] RD_DATA,
  // Status from the datapaths
  input wire logic IDLE_DETECTED,
  input wire logic CODE_WORD_FOUND,
  input wire logic DETECTOR_OUT,
  input wire logic RX_WORD_VALID,
  input wire slope_delta_codec_pll_ctrl_pkg::word_type RX_WORD,
  // PLL controls
  output logic [6:0] TX_SWALLOW,
  output logic [12:0] TX_MAIN,
  output logic TX_CP_HIGH,
  output logic [6:0] RX_SWALLOW,
  output logic [12:0] RX_MAIN,
  output logic RX_CP_HIGH,
  output logic [13:0] SECOND_LOCAL_OSCILLATOR_DIV,
  output logic SECOND_LOCAL_OSCILLATOR_CP_HIGH,
  output logic [11:0] REF_DIV,
  output logic MODULUS_RAIL_MODE,
  output logic TX_CP_INVERT,
  output logic RX_CP_INVERT,
  output logic SECOND_LOCAL_OSCILLATOR_CP_INVERT,
  output logic [2:0] TANK_CAP_SEL,
  // Codec controls
  output logic [1:0] DEC_MIN_STEP,
  output logic [1:0] ENC_MIN_STEP,
  output logic [1:0] CODEC_RATE,
  output logic [5:0] ENC_CLK_DIV,
  output logic [5:0] SCF_CLK_DIV,
  output logic RX_PATTERN_SEL,
  output logic TX_PATTERN_SEL,
  output logic CHARGE_COMP_DISABLE,
  // Idle channel detector
  output logic [3:0] IDLE_DELAY,
  output logic [2:0] IDLE_THRESH,
  output logic IDLE_AUTO_DISABLE,
  output logic ENC_IDLE_ACTION,
  // Data path controls
  output logic SLICER_INVERT,
  output logic MODEM_MODE,
  output logic CLKREC_BYPASS,
  output logic DETECT_BYPASS,
  output logic SCRAMBLE_BYPASS,
  output logic [2:0] SCRAMBLE_TAP,
  output logic CODE_WORD_LONG,
  output logic DATA_WORD_LONG,
  output logic [23:0] TX_CODE_WORD,
  output logic [23:0] TX_DATA_WORD,
  // Pins, audio and detector
  output logic [1:0] MULTIPURPOSE_PIN_ONE_SEL,
  output logic [1:0] MULTIPURPOSE_PIN_TWO_SEL,
  output logic PA_MUTE,
  output logic RX_MUTE,
  output logic TX_MUTE,
  output logic [4:0] RX_GAIN,
  output logic [4:0] TX_GAIN,
  output logic [2:0] DET_THRESH,
  output logic [3:0] BATTERY_REFERENCE_VOLTAGE_TRIM,
  output logic CARRIER_MODE
);
  import slope_delta_codec_pll_ctrl_pkg::*;

  // ******************************************************************
  // State
  // ******************************************************************
  bank_state_type state_q;
  bank_state_type state_d;

  // Masking keeps unassigned positions at zero, so they need no read filter.
  function automatic word_type masked_write(input word_type old_v, input word_type new_v,
                                            input word_type mask, input logic hit);
    masked_write = hit ? (new_v & mask) : old_v;
  endfunction : masked_write

  function automatic logic wr_hit(input logic stb, input reg_addr_type a,
                                  input reg_addr_type target);
    wr_hit = stb && (a == target);
  endfunction : wr_hit

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    state_d = state_q;
    state_d.tx_pll = masked_write(state_q.tx_pll, WR_DATA, `MASK_PLL_DIVIDER,
                                  wr_hit(WR_STROBE, WR_ADDR, `ADDR_TX_PLL_DIVIDER));
    state_d.rx_pll = masked_write(state_q.rx_pll, WR_DATA, `MASK_PLL_DIVIDER,
                                  wr_hit(WR_STROBE, WR_ADDR, `ADDR_RX_PLL_DIVIDER));
    state_d.lo2_det = masked_write(state_q.lo2_det, WR_DATA, `MASK_FULL_WORD,
                                   wr_hit(WR_STROBE, WR_ADDR, `ADDR_LO2_AND_DETECT));
    state_d.ref_clk = masked_write(state_q.ref_clk, WR_DATA, `MASK_FULL_WORD,
                                   wr_hit(WR_STROBE, WR_ADDR, `ADDR_REF_AND_CLK_DIV));
    state_d.idle_modem = masked_write(state_q.idle_modem, WR_DATA, `MASK_IDLE_MODEM,
                                      wr_hit(WR_STROBE, WR_ADDR, `ADDR_IDLE_MODEM_STATUS));
    state_d.mute_gain = 16'(masked_write({8'h00, state_q.mute_gain}, WR_DATA,
                            {8'h00, `MASK_MUTE_AND_GAIN},
                            wr_hit(WR_STROBE, WR_ADDR, `ADDR_MUTE_AND_GAIN)));
    state_d.loop_path = masked_write(state_q.loop_path, WR_DATA, `MASK_LOOP_AND_PATH,
                                     wr_hit(WR_STROBE, WR_ADDR, `ADDR_LOOP_AND_PATH));
    state_d.code_word = masked_write(state_q.code_word, WR_DATA, `MASK_FULL_WORD,
                                     wr_hit(WR_STROBE, WR_ADDR, `ADDR_TX_CODE_WORD));
    state_d.data_word = masked_write(state_q.data_word, WR_DATA, `MASK_FULL_WORD,
                                     wr_hit(WR_STROBE, WR_ADDR, `ADDR_TX_DATA_WORD));
    if (RX_WORD_VALID) begin
      state_d.rx_word = RX_WORD;
    end
    // The idle flag itself is always reported; only the encoder action is gated.
    state_d.enc_idle_action = IDLE_DETECTED & ~state_q.loop_path[`B_IDLE_AUTO_DIS];
    unique case (RD_ADDR)
      `ADDR_TX_PLL_DIVIDER: state_d.rd_data = state_q.tx_pll;
      `ADDR_RX_PLL_DIVIDER: state_d.rd_data = state_q.rx_pll;
      `ADDR_LO2_AND_DETECT: state_d.rd_data = state_q.lo2_det;
      `ADDR_REF_AND_CLK_DIV: state_d.rd_data = state_q.ref_clk;
      `ADDR_IDLE_MODEM_STATUS: begin
        state_d.rd_data = state_q.idle_modem;
        state_d.rd_data[`B_IDLE_STAT] = IDLE_DETECTED;
        state_d.rd_data[`B_CODE_STAT] = CODE_WORD_FOUND;
        state_d.rd_data[`B_DET_STAT] = DETECTOR_OUT;
      end
      `ADDR_MUTE_AND_GAIN: state_d.rd_data = {8'h00, state_q.mute_gain};
      `ADDR_LOOP_AND_PATH: state_d.rd_data = state_q.loop_path;
      `ADDR_TX_CODE_WORD: state_d.rd_data = state_q.code_word;
      `ADDR_TX_DATA_WORD: state_d.rd_data = state_q.data_word;
      `ADDR_RX_DATA_WORD: state_d.rd_data = state_q.rx_word;
      default: state_d.rd_data = 24'h000000;
    endcase
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state_q.tx_pll <= `RST_TX_PLL_DIVIDER;
      state_q.rx_pll <= `RST_RX_PLL_DIVIDER;
      state_q.lo2_det <= `RST_LO2_AND_DETECT;
      state_q.ref_clk <= `RST_REF_AND_CLK_DIV;
      state_q.idle_modem <= `RST_IDLE_MODEM_STATUS;
      state_q.mute_gain <= `RST_MUTE_AND_GAIN;
      state_q.loop_path <= `RST_LOOP_AND_PATH;
      state_q.code_word <= `RST_TX_CODE_WORD;
      state_q.data_word <= `RST_TX_DATA_WORD;
      state_q.rx_word <= `RST_RX_DATA_WORD;
      state_q.rd_data <= 24'h000000;
      state_q.enc_idle_action <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ******************************************************************
  // Field outputs
  // ******************************************************************
  assign RD_DATA = state_q.rd_data;
  assign TX_SWALLOW = state_q.tx_pll[`F_SWALLOW];
  assign TX_MAIN = state_q.tx_pll[`F_MAIN];
  assign TX_CP_HIGH = state_q.tx_pll[`B_CP_HIGH];
  assign DEC_MIN_STEP = state_q.tx_pll[`F_MIN_STEP];
  assign RX_SWALLOW = state_q.rx_pll[`F_SWALLOW];
  assign RX_MAIN = state_q.rx_pll[`F_MAIN];
  assign RX_CP_HIGH = state_q.rx_pll[`B_CP_HIGH];
  assign ENC_MIN_STEP = state_q.rx_pll[`F_MIN_STEP];
  assign SECOND_LOCAL_OSCILLATOR_DIV = state_q.lo2_det[`F_LO2_DIV];
  assign SECOND_LOCAL_OSCILLATOR_CP_HIGH = state_q.lo2_det[`B_LO2_CP_HIGH];
  assign CODEC_RATE = state_q.lo2_det[`F_CODEC_RATE];
  assign BATTERY_REFERENCE_VOLTAGE_TRIM = state_q.lo2_det[`F_DET_TRIM];
  assign DET_THRESH = state_q.lo2_det[`F_DET_THRESH];
  assign REF_DIV = state_q.ref_clk[`F_REF_DIV];
  assign SCF_CLK_DIV = state_q.ref_clk[`F_SCF_DIV];
  assign ENC_CLK_DIV = state_q.ref_clk[`F_ENC_CLK_DIV];
  assign IDLE_DELAY = state_q.idle_modem[`F_IDLE_DELAY];
  assign IDLE_THRESH = state_q.idle_modem[`F_IDLE_THRESH];
  assign SLICER_INVERT = state_q.idle_modem[`B_SLICER_INV];
  assign MODEM_MODE = state_q.idle_modem[`B_MODEM_MODE];
  assign PA_MUTE = state_q.mute_gain[`B_PA_MUTE];
  assign RX_MUTE = state_q.mute_gain[`B_RX_MUTE];
  assign TX_MUTE = state_q.mute_gain[`B_TX_MUTE];
  assign RX_PATTERN_SEL = state_q.mute_gain[`B_RX_PATTERN];
  assign TX_PATTERN_SEL = state_q.mute_gain[`B_TX_PATTERN];
  assign CARRIER_MODE = state_q.mute_gain[`B_CARRIER_MODE];
  assign RX_GAIN = state_q.mute_gain[`F_RX_GAIN];
  assign TX_GAIN = state_q.mute_gain[`F_TX_GAIN];
  assign CLKREC_BYPASS = state_q.loop_path[`B_CLKREC_BYP];
  assign SCRAMBLE_BYPASS = state_q.loop_path[`B_SCRAMBLE_BYP];
  assign IDLE_AUTO_DISABLE = state_q.loop_path[`B_IDLE_AUTO_DIS];
  assign DETECT_BYPASS = state_q.loop_path[`B_DETECT_BYP];
  assign MULTIPURPOSE_PIN_ONE_SEL = state_q.loop_path[`F_MP_ONE];
  assign MULTIPURPOSE_PIN_TWO_SEL = state_q.loop_path[`F_MP_TWO];
  assign SCRAMBLE_TAP = state_q.loop_path[`F_SCRAMBLE_TAP];
  assign CODE_WORD_LONG = state_q.loop_path[`B_CODE_LONG];
  assign DATA_WORD_LONG = state_q.loop_path[`B_DATA_LONG];
  assign MODULUS_RAIL_MODE = state_q.loop_path[`B_RAIL_MODE];
  assign CHARGE_COMP_DISABLE = state_q.loop_path[`B_CHARGE_COMP_DIS];
  assign TANK_CAP_SEL = state_q.loop_path[`F_TANK_SEL];
  assign SECOND_LOCAL_OSCILLATOR_CP_INVERT = state_q.loop_path[`B_LO2_CP_INV];
  assign RX_CP_INVERT = state_q.loop_path[`B_RX_CP_INV];
  assign TX_CP_INVERT = state_q.loop_path[`B_TX_CP_INV];
  assign ENC_IDLE_ACTION = state_q.enc_idle_action;
  assign TX_CODE_WORD = state_q.code_word;
  assign TX_DATA_WORD = state_q.data_word;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  pll_reset_value_a: assert property (
    $rose(NRST)
    |-> TX_SWALLOW == 7'h40 && TX_MAIN == 13'h0004
  )
    else $error("Transmit PLL counters wrong after reset.");

  lo2_write_a: assert property (
    WR_STROBE && WR_ADDR == 4'h3
    |=> SECOND_LOCAL_OSCILLATOR_DIV == $past(WR_DATA[13:0])
  )
    else $error("Second oscillator divider did not take the write.");

  ref_reset_a: assert property (
    $rose(NRST)
    |-> REF_DIV == 12'h800 && ENC_CLK_DIV == 6'h20
  )
    else $error("Reference or encoder divider wrong after reset.");

  unused_bits_a: assert property (
    RD_ADDR == 4'h7
    |=> RD_DATA[17:15] == 3'h0
  )
    else $error("Test-mode field read back non-zero.");

  idle_action_a: assert property (
    IDLE_AUTO_DISABLE
    |=> !ENC_IDLE_ACTION
  )
    else $error("Encoder idle action while disabled.");

  idle_status_a: assert property (
    RD_ADDR == 4'h5
    |=> RD_DATA[21] == $past(IDLE_DETECTED) && RD_DATA[22] == $past(CODE_WORD_FOUND)
  )
    else $error("Status bits not read back.");

  rx_word_a: assert property (
    RX_WORD_VALID ##1 RD_ADDR == 4'hA
    |=> RD_DATA == $past(RX_WORD, 2)
  )
    else $error("Received word not returned.");

  word_size_a: assert property (
    $rose(NRST)
    |-> CODE_WORD_LONG && DATA_WORD_LONG && SCRAMBLE_TAP == 3'h2
  )
    else $error("Word size or tap default wrong.");

  gain_reset_a: assert property (
    $rose(NRST)
    |-> RX_GAIN == 5'h0F && TX_GAIN == 5'h04 && !PA_MUTE
  )
    else $error("Gain defaults wrong after reset.");

  unmapped_read_a: assert property (
    RD_ADDR == 4'h0 || RD_ADDR > 4'hA
    |=> RD_DATA == 24'h000000
  )
    else $error("Unmapped register read non-zero.");

  codec_reset_a: assert property (
    $rose(NRST)
    |-> CODEC_RATE == 2'h3 && IDLE_DELAY == 4'h7 && IDLE_THRESH == 3'h4
  )
    else $error("Codec or idle defaults wrong.");

  det_reset_a: assert property (
    $rose(NRST)
    |-> DET_THRESH == 3'h3 && BATTERY_REFERENCE_VOLTAGE_TRIM == 4'h7
  )
    else $error("Detector defaults wrong.");

  pll_write_a: assert property (
    WR_STROBE && WR_ADDR == 4'h1
    |=> TX_MAIN == $past(WR_DATA[19:7]) && DEC_MIN_STEP == $past(WR_DATA[22:21])
  )
    else $error("Transmit divider write lost.");

  cp_current_a: assert property (
    WR_STROBE && WR_ADDR == 4'h2
    |=> RX_CP_HIGH == $past(WR_DATA[20]) && ENC_MIN_STEP == $past(WR_DATA[22:21])
  )
    else $error("Receive divider write lost.");

  ref_write_a: assert property (
    WR_STROBE && WR_ADDR == 4'h4
    |=> REF_DIV == $past(WR_DATA[11:0]) && SCF_CLK_DIV == $past(WR_DATA[17:12])
  )
    else $error("Clock divider write lost.");

  idle_write_a: assert property (
    WR_STROBE && WR_ADDR == 4'h5
    |=> IDLE_THRESH == $past(WR_DATA[17:15]) && MODEM_MODE == $past(WR_DATA[20])
  )
    else $error("Idle or modem write lost.");

  mute_write_a: assert property (
    WR_STROBE && WR_ADDR == 4'h6
    |=> {TX_PATTERN_SEL, RX_PATTERN_SEL, TX_MUTE, RX_MUTE, PA_MUTE} == $past(WR_DATA[4:0])
  )
    else $error("Mute or pattern write lost.");

  gain_write_a: assert property (
    WR_STROBE && WR_ADDR == 4'h6
    |=> RX_GAIN == $past(WR_DATA[10:6]) && TX_GAIN == $past(WR_DATA[15:11])
  )
    else $error("Gain write lost.");

  loop_write_a: assert property (
    WR_STROBE && WR_ADDR == 4'h7
    |=> MODULUS_RAIL_MODE == $past(WR_DATA[13]) && TX_CP_INVERT == $past(WR_DATA[23])
  )
    else $error("Loop option write lost.");

  tank_write_a: assert property (
    WR_STROBE && WR_ADDR == 4'h7
    |=> TANK_CAP_SEL == $past(WR_DATA[20:18]) && SCRAMBLE_TAP == $past(WR_DATA[10:8])
  )
    else $error("Tank or tap write lost.");

  tx_words_a: assert property (
    WR_STROBE && WR_ADDR == 4'h8
    |=> TX_CODE_WORD == $past(WR_DATA)
  )
    else $error("Code word write lost.");

  detect_status_a: assert property (
    RD_ADDR == 4'h5
    |=> RD_DATA[23] == $past(DETECTOR_OUT)
  )
    else $error("Detector output not read back.");

endmodule : slope_delta_codec_pll_control_register_bank

`default_nettype wire

// [rtl/slope_delta_codec_pll_ctrl_regs.svh]
`ifndef SLOPE_DELTA_CODEC_PLL_CTRL_REGS_SVH
`define SLOPE_DELTA_CODEC_PLL_CTRL_REGS_SVH

// ********************************************************************
// Register numbers on the control port
// ********************************************************************
`define ADDR_TX_PLL_DIVIDER 4'h1
`define ADDR_RX_PLL_DIVIDER 4'h2
`define ADDR_LO2_AND_DETECT 4'h3
`define ADDR_REF_AND_CLK_DIV 4'h4
`define ADDR_IDLE_MODEM_STATUS 4'h5
`define ADDR_MUTE_AND_GAIN 4'h6
`define ADDR_LOOP_AND_PATH 4'h7
`define ADDR_TX_CODE_WORD 4'h8
`define ADDR_TX_DATA_WORD 4'h9
`define ADDR_RX_DATA_WORD 4'hA

// ********************************************************************
// Power-up values
// ********************************************************************
`define RST_TX_PLL_DIVIDER 24'h000240
`define RST_RX_PLL_DIVIDER 24'h000240
`define RST_LO2_AND_DETECT 24'h6F8004
`define RST_REF_AND_CLK_DIV 24'h820800
`define RST_IDLE_MODEM_STATUS 24'h023800
`define RST_MUTE_AND_GAIN 16'h23C0
`define RST_LOOP_AND_PATH 24'h001A00
`define RST_TX_CODE_WORD 24'h000000
`define RST_TX_DATA_WORD 24'h000000
`define RST_RX_DATA_WORD 24'h000000

// ********************************************************************
// Writable bit masks
// ********************************************************************
`define MASK_PLL_DIVIDER 24'h7FFFFF
`define MASK_FULL_WORD 24'hFFFFFF
`define MASK_IDLE_MODEM 24'h1BF800
`define MASK_MUTE_AND_GAIN 16'hFFFF
`define MASK_LOOP_AND_PATH 24'hFC7FFF

// ********************************************************************
// Field positions
// ********************************************************************
`define F_SWALLOW 6:0
`define F_MAIN 19:7
`define B_CP_HIGH 20
`define F_MIN_STEP 22:21
`define F_LO2_DIV 13:0
`define B_LO2_CP_HIGH 14
`define F_CODEC_RATE 16:15
`define F_DET_TRIM 20:17
`define F_DET_THRESH 23:21
`define F_REF_DIV 11:0
`define F_SCF_DIV 17:12
`define F_ENC_CLK_DIV 23:18
`define F_IDLE_DELAY 14:11
`define F_IDLE_THRESH 17:15
`define B_SLICER_INV 19
`define B_MODEM_MODE 20
`define B_IDLE_STAT 21
`define B_CODE_STAT 22
`define B_DET_STAT 23
`define B_PA_MUTE 0
`define B_RX_MUTE 1
`define B_TX_MUTE 2
`define B_RX_PATTERN 3
`define B_TX_PATTERN 4
`define B_CARRIER_MODE 5
`define F_RX_GAIN 10:6
`define F_TX_GAIN 15:11
`define B_CLKREC_BYP 0
`define B_SCRAMBLE_BYP 1
`define B_IDLE_AUTO_DIS 2
`define B_DETECT_BYP 3
`define F_MP_ONE 5:4
`define F_MP_TWO 7:6
`define F_SCRAMBLE_TAP 10:8
`define B_CODE_LONG 11
`define B_DATA_LONG 12
`define B_RAIL_MODE 13
`define B_CHARGE_COMP_DIS 14
`define F_TANK_SEL 20:18
`define B_LO2_CP_INV 21
`define B_RX_CP_INV 22
`define B_TX_CP_INV 23

`endif

// [rtl/slope_delta_codec_pll_ctrl_pkg.sv]
package slope_delta_codec_pll_ctrl_pkg;

  typedef logic [23:0] word_type;
  typedef logic [3:0] reg_addr_type;

  typedef struct packed {
    word_type tx_pll;
    word_type rx_pll;
    word_type lo2_det;
    word_type ref_clk;
    word_type idle_modem;
    logic [15:0] mute_gain;
    word_type loop_path;
    word_type code_word;
    word_type data_word;
    word_type rx_word;
    word_type rd_data;
    logic enc_idle_action;
  } bank_state_type;

endpackage : slope_delta_codec_pll_ctrl_pkg

// [verif/host_port_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ********************************************************************
// Host side of the parallel register port
// ********************************************************************
module host_port_model (
  // Clock
  input wire logic SYS_CLK,
  // Requests towards the bank
  output logic WR_STROBE,
  output slope_delta_codec_pll_ctrl_pkg::reg_addr_type WR_ADDR,
  output slope_delta_codec_pll_ctrl_pkg::word_type WR_DATA,
  output slope_delta_codec_pll_ctrl_pkg::reg_addr_type RD_ADDR,
  output logic RD_GO
);
  import slope_delta_codec_pll_ctrl_pkg::*;

  initial begin
    WR_STROBE = 1'b0;
    WR_ADDR = 4'h0;
    WR_DATA = 24'h000000;
    RD_ADDR = 4'h0;
    RD_GO = 1'b0;
  end

  // Each request is raised just after an edge and taken at the next one.
  task automatic write_reg(input reg_addr_type a, input word_type d);
    @(posedge SYS_CLK);
    WR_STROBE <= 1'b1;
    WR_ADDR <= a;
    WR_DATA <= d;
  endtask : write_reg

  task automatic read_reg(input reg_addr_type a);
    @(posedge SYS_CLK);
    RD_ADDR <= a;
    RD_GO <= 1'b1;
  endtask : read_reg

  // Released data is inverted so that a stale word can never pass for a fresh one.
  task automatic idle();
    @(posedge SYS_CLK);
    WR_STROBE <= 1'b0;
    RD_GO <= 1'b0;
    WR_DATA <= ~WR_DATA;
  endtask : idle
endmodule : host_port_model

`default_nettype wire

// [verif/tb_slope_delta_codec_pll_control_register_bank.sv]
`timescale 1ns/1ns
`default_nettype none

// ********************************************************************
// Bench for the control register bank
// ********************************************************************
module tb_slope_delta_codec_pll_control_register_bank;
  import slope_delta_codec_pll_ctrl_pkg::*;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic IDLE_DETECTED = 1'b0;
  logic CODE_WORD_FOUND = 1'b0;
  logic DETECTOR_OUT = 1'b0;
  logic RX_WORD_VALID = 1'b0;
  word_type RX_WORD = 24'h000000;
  logic WR_STROBE, RD_GO;
  reg_addr_type WR_ADDR, RD_ADDR;
  word_type WR_DATA;
  logic [23:0] RD_DATA, TX_CODE_WORD, TX_DATA_WORD;
  logic [6:0] TX_SWALLOW, RX_SWALLOW;
  logic [12:0] TX_MAIN, RX_MAIN;
  logic [13:0] SECOND_LOCAL_OSCILLATOR_DIV;
  logic [11:0] REF_DIV;
  logic [5:0] ENC_CLK_DIV, SCF_CLK_DIV;
  logic [4:0] RX_GAIN, TX_GAIN;
  logic [3:0] IDLE_DELAY, BATTERY_REFERENCE_VOLTAGE_TRIM;
  logic [2:0] TANK_CAP_SEL, IDLE_THRESH, SCRAMBLE_TAP, DET_THRESH;
  logic [1:0] DEC_MIN_STEP, ENC_MIN_STEP, CODEC_RATE;
  logic [1:0] MULTIPURPOSE_PIN_ONE_SEL, MULTIPURPOSE_PIN_TWO_SEL;
  logic TX_CP_HIGH, RX_CP_HIGH, SECOND_LOCAL_OSCILLATOR_CP_HIGH, MODULUS_RAIL_MODE;
  logic TX_CP_INVERT, RX_CP_INVERT, SECOND_LOCAL_OSCILLATOR_CP_INVERT, RX_PATTERN_SEL;
  logic TX_PATTERN_SEL, CHARGE_COMP_DISABLE, IDLE_AUTO_DISABLE, ENC_IDLE_ACTION;
  logic SLICER_INVERT, MODEM_MODE, CLKREC_BYPASS, DETECT_BYPASS, SCRAMBLE_BYPASS;
  logic CODE_WORD_LONG, DATA_WORD_LONG, PA_MUTE, RX_MUTE, TX_MUTE, CARRIER_MODE;
  integer seed = 32'hB463;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic rd_go_q = 1'b0;
  word_type w;
  word_type exp_q[$];
  word_type mdl [16];
  // Writable bits; the receive word and unmapped places take no writes.
  word_type mask [16] = '{1: 24'h7FFFFF, 2: 24'h7FFFFF, 3: 24'hFFFFFF, 4: 24'hFFFFFF,
    5: 24'h1BF800, 6: 24'h00FFFF, 7: 24'hFC7FFF, 8: 24'hFFFFFF, 9: 24'hFFFFFF,
    default: 24'h000000};
  word_type dflt [16] = '{1: 24'h000240, 2: 24'h000240, 3: 24'h6F8004, 4: 24'h820800,
    5: 24'h023800, 6: 24'h0023C0, 7: 24'h001A00, default: 24'h000000};

  always #2 SYS_CLK = ~SYS_CLK;

  host_port_model u_host_port_model (.SYS_CLK, .WR_STROBE, .WR_ADDR, .WR_DATA, .RD_ADDR,
    .RD_GO);
  slope_delta_codec_pll_control_register_bank u_slope_delta_codec_pll_control_register_bank (.SYS_CLK, .NRST,
    .WR_STROBE, .WR_ADDR, .WR_DATA, .RD_ADDR, .RD_DATA, .IDLE_DETECTED, .CODE_WORD_FOUND,
    .DETECTOR_OUT, .RX_WORD_VALID, .RX_WORD, .TX_SWALLOW, .TX_MAIN, .TX_CP_HIGH, .RX_SWALLOW,
    .RX_MAIN, .RX_CP_HIGH, .SECOND_LOCAL_OSCILLATOR_DIV, .SECOND_LOCAL_OSCILLATOR_CP_HIGH,
    .REF_DIV, .MODULUS_RAIL_MODE, .TX_CP_INVERT, .RX_CP_INVERT, .TANK_CAP_SEL,
    .SECOND_LOCAL_OSCILLATOR_CP_INVERT, .DEC_MIN_STEP, .ENC_MIN_STEP, .CODEC_RATE,
    .ENC_CLK_DIV, .SCF_CLK_DIV, .RX_PATTERN_SEL, .TX_PATTERN_SEL, .CHARGE_COMP_DISABLE,
    .IDLE_DELAY, .IDLE_THRESH, .IDLE_AUTO_DISABLE, .ENC_IDLE_ACTION, .SLICER_INVERT,
    .MODEM_MODE, .CLKREC_BYPASS, .DETECT_BYPASS, .SCRAMBLE_BYPASS, .SCRAMBLE_TAP,
    .CODE_WORD_LONG, .DATA_WORD_LONG, .TX_CODE_WORD, .TX_DATA_WORD, .MULTIPURPOSE_PIN_ONE_SEL,
    .MULTIPURPOSE_PIN_TWO_SEL, .PA_MUTE, .RX_MUTE, .TX_MUTE, .RX_GAIN, .TX_GAIN, .DET_THRESH,
    .BATTERY_REFERENCE_VOLTAGE_TRIM, .CARRIER_MODE);

  // Field outputs put back at their register positions.
  function automatic word_type fields(input reg_addr_type a);
    case (a)
      4'h1: return {1'b0, DEC_MIN_STEP, TX_CP_HIGH, TX_MAIN, TX_SWALLOW};
      4'h2: return {1'b0, ENC_MIN_STEP, RX_CP_HIGH, RX_MAIN, RX_SWALLOW};
      4'h3: return {DET_THRESH, BATTERY_REFERENCE_VOLTAGE_TRIM, CODEC_RATE,
        SECOND_LOCAL_OSCILLATOR_CP_HIGH, SECOND_LOCAL_OSCILLATOR_DIV};
      4'h4: return {ENC_CLK_DIV, SCF_CLK_DIV, REF_DIV};
      4'h5: return {3'h0, MODEM_MODE, SLICER_INVERT, 1'b0, IDLE_THRESH, IDLE_DELAY, 11'h0};
      4'h6: return {8'h00, TX_GAIN, RX_GAIN, CARRIER_MODE, TX_PATTERN_SEL, RX_PATTERN_SEL,
        TX_MUTE, RX_MUTE, PA_MUTE};
      4'h7: return {TX_CP_INVERT, RX_CP_INVERT, SECOND_LOCAL_OSCILLATOR_CP_INVERT, TANK_CAP_SEL,
        3'h0, CHARGE_COMP_DISABLE, MODULUS_RAIL_MODE, DATA_WORD_LONG, CODE_WORD_LONG,
        SCRAMBLE_TAP, MULTIPURPOSE_PIN_TWO_SEL, MULTIPURPOSE_PIN_ONE_SEL, DETECT_BYPASS,
        IDLE_AUTO_DISABLE, SCRAMBLE_BYPASS, CLKREC_BYPASS};
      4'h8: return TX_CODE_WORD;
      4'h9: return TX_DATA_WORD;
      default: return 24'h000000;
    endcase
  endfunction : fields

  function automatic word_type exp_rd(input reg_addr_type a);
    if (a == 4'h5) return mdl[a] | {DETECTOR_OUT, CODE_WORD_FOUND, IDLE_DETECTED, 21'h0};
    return mdl[a];
  endfunction : exp_rd

  task automatic check(input word_type seen, input word_type want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check

  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic wr(input reg_addr_type a, input word_type d);
    u_host_port_model.write_reg(a, d);
    if (a != 4'hA) mdl[a] = d & mask[a];
  endtask : wr

  task automatic rd(input reg_addr_type a);
    exp_q.push_back(exp_rd(a));
    u_host_port_model.read_reg(a);
  endtask : rd

  task automatic drain();
    u_host_port_model.idle();
    repeat (2) @(negedge SYS_CLK);
  endtask : drain

  task automatic audit(input string name);
    for (int a = 0; a < 16; a++) rd(4'(a));
    drain();
    for (int a = 1; a < 10; a++) begin
      check(fields(4'(a)), mdl[a]);
    end
    $display("Test %s done", name);
  endtask : audit

  task automatic do_reset();
    NRST <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    NRST <= 1'b1;
    for (int i = 0; i < 16; i++) mdl[i] = dflt[i];
  endtask : do_reset

  // ********************************************************************
  // Read monitor and watchdog
  // ********************************************************************
  always @(posedge SYS_CLK) rd_go_q <= RD_GO;
  always @(negedge SYS_CLK) begin
    if (rd_go_q && exp_q.size() > 0) check(RD_DATA, exp_q.pop_front());
  end
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    do_reset();
    audit("defaults");
    for (int v = 0; v < 3; v++) begin
      for (int a = 0; a < 16; a++) wr(4'(a), (v == 0) ? 24'hFFFFFF : 24'($random(seed)) & {24{v[1]}});
      u_host_port_model.idle();
      audit("write sweep");
    end
    // Idle detection must stay visible in status even while the encoder action is off.
    for (int k = 0; k < 8; k++) begin
      @(posedge SYS_CLK);
      {IDLE_DETECTED, CODE_WORD_FOUND, DETECTOR_OUT} <= 3'(k);
      w = $random(seed);
      w[2] = k[1];
      wr(4'h7, w);
      u_host_port_model.idle();
      repeat (2) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      check(word_type'(ENC_IDLE_ACTION), word_type'(IDLE_DETECTED & ~w[2]));
      rd(4'h5);
      drain();
    end
    $display("Test status done");
    rd(4'hA);
    drain();
    for (int j = 0; j < 3; j++) begin
      @(posedge SYS_CLK);
      w = $random(seed);
      RX_WORD_VALID <= 1'b1;
      RX_WORD <= w;
    end
    @(posedge SYS_CLK);
    RX_WORD_VALID <= 1'b0;
    RX_WORD <= ~w;
    mdl[10] = w;
    wr(4'hA, ~w);
    u_host_port_model.idle();
    audit("receive word");
    @(posedge SYS_CLK);
    do_reset();
    audit("second reset");
    final_report();
  end
endmodule : tb_slope_delta_codec_pll_control_register_bank

`default_nettype wire
